// *** pkg/ams_defs.svh ***
// Constants for the automatic message sequencers: register map,
// field positions, reset values and fixed character codes.
// Assumes inclusion by bare name from any file that needs a number.
`ifndef AMS_DEFS_SVH
`define AMS_DEFS_SVH

// Register byte offsets
`define AMS_REG_CTRL 8'h00
`define AMS_REG_AUX 8'h04
`define AMS_REG_MSG 8'h08
`define AMS_REG_STAT 8'h0c

// Field positions
`define AMS_CTRL_END_LSB 0
`define AMS_MSG_IDX_LSB 0
`define AMS_MSG_CHR_LSB 8
`define AMS_AUX_C1_LSB 8
`define AMS_AUX_C2_LSB 16

// Reset values
`define AMS_END_RST 4'h4
`define AMS_AUX_RST 7'h20
`define AMS_FOX_IDLE 6'h3f
`define AMS_LINES_OFF 7'h7f

// Fixed calling string: C, Q, space
`define AMS_CALL_C0 7'h43
`define AMS_CALL_C1 7'h51
`define AMS_CALL_C2 7'h20

// Three-character counter end state
`define AMS_SEQ3_DONE 2'h3

`endif

// *** pkg/ams_pkg.sv ***
// Types shared by the automatic message sequencers.
// Assumes nothing beyond a SystemVerilog compiler.
package ams_pkg;

	// Start keys, all active low as they come off the switches
	typedef struct packed {
		logic fox_n;
		logic identify_n;
		logic calling_n;
		logic aux_n;
	} ams_keys_n_t;

	// Which sequencer a start request is granted to
	typedef enum logic [2:0] {
		GR_NONE,
		GR_FOX,
		GR_ID,
		GR_CALL,
		GR_AUX
	} ams_grant_t;

	// Running indications seen by the buffer control
	typedef struct packed {
		logic fox_active;
		logic identifier_running;
		logic group_running;
		logic sequencer_busy;
		logic keyboard_inhibit;
	} ams_status_t;

endpackage

// *** src/ams_id_rom.sv ***
// Identifier message store: sixteen seven-bit ASCII characters.
// Assumes one writer from the register bus; read data are registered.
`timescale 1ns/1ps

module ams_id_rom
#(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 7
)
(
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [DEPTH];

	// ==========================================
	// Storage; no reset, software loads the message
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule // ams_id_rom

// *** src/ams_seq3.sv ***
// One three-character sequencer: a two-bit position counter.
// Assumes start and step pulses from the same clock, start only when idle.
`timescale 1ns/1ps

module ams_seq3
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic step,
	output logic [1:0] cnt,
	output logic running
);
	import ams_pkg::*;
	`include "ams_defs.svh"

	wire at_end = (cnt == `AMS_SEQ3_DONE);
	wire [1:0] next_cnt = start ? 2'h0 : (cnt + 2'h1);

	// ==========================================
	// Counter; stops in its fourth state so no more strobes count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= `AMS_SEQ3_DONE;
			running <= 1'b0;
		end
		else if (start)
		begin
			cnt <= next_cnt;
			running <= 1'b1;
		end
		else if (running && step && !at_end)
		begin
			cnt <= next_cnt;
			running <= (next_cnt != `AMS_SEQ3_DONE);
		end
	end

	// ==========================================
	sequence seq3_launch;
		start ##1 (running && cnt == 2'h0);
	endsequence

	start_runs_a: assert property (@(posedge pclk) disable iff (!presetn)
		start |-> seq3_launch)
		else $error("three-char start did not run");

	stop_third_a: assert property (@(posedge pclk) disable iff (!presetn)
		(running && step && cnt == 2'h2 && !start) |=> (!running && at_end))
		else $error("three-char did not stop after third");

endmodule // ams_seq3

// *** src/ams_top.sv ***
// Automatic message sequencers: fox test message control, station
// identifier and two three-character strings, with an APB register file.
// Assumes keys and mode select are asynchronous pins; the strobe from the
// buffer control and all APB signals are on pclk.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps

module ams_top
#(
	parameter int FLUSH_DIV = 4,
	parameter int ID_DEPTH = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ams_pkg::ams_keys_n_t keys_n,
	input wire logic morse_mode,
	input wire logic next_char_strobe,
	output logic [6:0] data_lines_n,
	output logic [15:0] id_select_n,
	output logic [7:0] fox_addr,
	output ams_pkg::ams_status_t status
);
	import ams_pkg::*;
	`include "ams_defs.svh"

	// ==========================================
	// Pin synchronisers: keys and mode select come from switches
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta <= 5'h1e;
			pin_sync <= 5'h1e;
		end
		else
		begin
			pin_meta <= {keys_n, morse_mode};
			pin_sync <= pin_meta;
		end
	end

	wire fox_key = !pin_sync[4];
	wire id_key = !pin_sync[3];
	wire call_key = !pin_sync[2];
	wire aux_key = !pin_sync[1];
	wire morse_s = pin_sync[0];

	// ==========================================
	// Registers
	logic [3:0] id_end;
	logic [20:0] aux_chars;
	logic strobe_q;
	logic [5:0] fox_cnt;
	logic [3:0] id_cnt;
	logic id_running;
	logic [1:0] g_cnt [2];
	logic [1:0] g_run;
	logic [$clog2(FLUSH_DIV+1)-1:0] flush_div;
	logic [6:0] id_code;
	wire fox_at_idle = (fox_cnt == `AMS_FOX_IDLE);

	// ==========================================
	// APB decode; zero wait states, pready comes in the access cycle
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite && pready;
	wire hit_ctrl = (paddr == `AMS_REG_CTRL);
	wire hit_aux = (paddr == `AMS_REG_AUX);
	wire hit_msg = (paddr == `AMS_REG_MSG);
	wire hit_stat = (paddr == `AMS_REG_STAT);
	wire hit_any = hit_ctrl || hit_aux || hit_msg || hit_stat;
	wire msg_we = apb_wr && hit_msg;
	wire [3:0] msg_idx = pwdata[`AMS_MSG_IDX_LSB +: 4];
	wire [6:0] msg_chr = pwdata[`AMS_MSG_CHR_LSB +: 7];
	wire [31:0] stat_word = {14'h0000, fox_cnt, id_cnt, g_cnt[1],
		g_cnt[0], g_run, id_running, !fox_at_idle};
	wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, id_end} :
		hit_aux ? {8'h00, 1'b0, aux_chars[20:14], 1'b0, aux_chars[13:7],
			1'b0, aux_chars[6:0]} :
		hit_stat ? stat_word : 32'h00000000;

	// Bus response registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup && !hit_any;
			prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Control registers; the end marker plays the jumper's part
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			id_end <= `AMS_END_RST;
			aux_chars <= {`AMS_AUX_RST, `AMS_AUX_RST, `AMS_AUX_RST};
		end
		else if (apb_wr && hit_ctrl)
			id_end <= pwdata[`AMS_CTRL_END_LSB +: 4];
		else if (apb_wr && hit_aux)
			aux_chars <= {pwdata[`AMS_AUX_C2_LSB +: 7],
				pwdata[`AMS_AUX_C1_LSB +: 7], pwdata[6:0]};
	end

	// ==========================================
	// Start arbitration; one grant per cycle keeps sequencers exclusive
	wire busy_any = !fox_at_idle || id_running || (|g_run);
	wire fox_req = fox_key && !morse_s;
	wire ams_grant_t grant = busy_any ? GR_NONE :
		fox_req ? GR_FOX :
		id_key ? GR_ID :
		call_key ? GR_CALL :
		aux_key ? GR_AUX : GR_NONE;
	wire fox_go = (grant == GR_FOX);
	wire id_go = (grant == GR_ID);
	wire [1:0] g_go = {grant == GR_AUX, grant == GR_CALL};

	// Strobe counted once per pulse; it spans two base periods
	wire step = next_char_strobe && !strobe_q && busy_any;
	wire flush_tick = (flush_div == 0);
	wire fox_flush = !fox_at_idle && morse_s && flush_tick;
	wire fox_step = !fox_at_idle && !morse_s && step;
	wire id_at_end = (id_cnt == id_end);

	// ==========================================
	// Fast flush divider and strobe edge history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flush_div <= '0;
			strobe_q <= 1'b0;
		end
		else
		begin
			flush_div <= flush_tick ? FLUSH_DIV[$bits(flush_div)-1:0] - 1'b1 :
				flush_div - 1'b1;
			strobe_q <= next_char_strobe;
		end
	end

	// Fox counter: all ones is idle, so a wild power-up state is flushed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fox_cnt <= `AMS_FOX_IDLE;
		else if (fox_go)
			fox_cnt <= 6'h00;
		else if (fox_step || fox_flush)
			fox_cnt <= fox_cnt + 6'h01;
	end

	// Identifier counter and running flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			id_cnt <= 4'h0;
			id_running <= 1'b0;
		end
		else if (id_go)
		begin
			id_cnt <= 4'h0;
			id_running <= 1'b1;
		end
		else if (id_running && id_at_end)
			id_running <= 1'b0;
		else if (id_running && step)
			id_cnt <= id_cnt + 4'h1;
	end

	// ==========================================
	// Two three-character sequencers
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_seq
			ams_seq3 u_seq
			(
				.pclk(pclk),
				.presetn(presetn),
				.start(g_go[g]),
				.step(step),
				.cnt(g_cnt[g]),
				.running(g_run[g])
			);
		end
	endgenerate

	// Start reads slot zero at once, so no stale code from the last run
	// reaches the lines while the counter is being cleared
	wire [3:0] id_raddr = id_go ? 4'h0 : id_cnt;

	// Identifier message; one cycle of read latency before the lines
	ams_id_rom #(.DEPTH(ID_DEPTH)) u_rom
	(
		.clk(pclk),
		.we(msg_we),
		.waddr(msg_idx),
		.wdata(msg_chr),
		.raddr(id_raddr),
		.rdata(id_code)
	);

	// ==========================================
	// Character matrices for the group sequencers
	wire [6:0] call_chr = (g_cnt[0] == 2'h0) ? `AMS_CALL_C0 :
		(g_cnt[0] == 2'h1) ? `AMS_CALL_C1 : `AMS_CALL_C2;
	wire [6:0] aux_chr = aux_chars[7*g_cnt[1] +: 7];
	wire [6:0] grp_chr = g_run[0] ? call_chr : aux_chr;
	wire drive = id_running || (|g_run);
	wire [6:0] code = id_running ? id_code : grp_chr;
	wire [15:0] sel_onehot = 16'h0001 << id_cnt;
	wire [7:0] fox_a = {fox_cnt[5], 2'b00, fox_cnt[4:0]};

	// Output stage; negative-true lines released high when idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			data_lines_n <= `AMS_LINES_OFF;
			id_select_n <= 16'hffff;
			fox_addr <= 8'h00;
			status <= '0;
		end
		else
		begin
			data_lines_n <= drive ? ~code : `AMS_LINES_OFF;
			id_select_n <= id_running ? ~sel_onehot : 16'hffff;
			fox_addr <= fox_at_idle ? 8'h00 : fox_a;
			status.fox_active <= !fox_at_idle;
			status.identifier_running <= id_running;
			status.group_running <= |g_run;
			status.sequencer_busy <= busy_any;
			status.keyboard_inhibit <= busy_any;
		end
	end

	// ==========================================
	// Checks
	sequence id_launch;
		id_go ##1 (id_running && id_cnt == 4'h0);
	endsequence

	morse_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		(morse_s && fox_at_idle) |=> fox_at_idle)
		else $error("fox started in Morse mode");

	flush_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		fox_flush |=> (fox_cnt == $past(fox_cnt) + 6'h01))
		else $error("flush tick did not step fox counter");

	select_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		id_running |=> $onehot0(~id_select_n))
		else $error("identifier selects not one-hot");

	lines_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		drive |=> (data_lines_n == ~$past(code)))
		else $error("data lines do not carry the code");

	id_adv_a: assert property (@(posedge pclk) disable iff (!presetn)
		(id_running && step && !id_at_end && !id_go) |=>
		(id_cnt == $past(id_cnt) + 4'h1))
		else $error("identifier did not advance");

	id_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(id_key && !busy_any && !fox_req) |-> id_launch)
		else $error("identify key did not start identifier");

	busy_id_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(id_running) |=> status.sequencer_busy [*1])
		else $error("busy not raised for identifier");

	id_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		(id_running && id_at_end) |=> !id_running)
		else $error("identifier ran past end marker");

	exclusive_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0({!fox_at_idle, id_running, g_run}))
		else $error("two sequencers running at once");

	inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_any |=> status.keyboard_inhibit)
		else $error("keyboard not inhibited while busy");

endmodule // ams_top

// *** test/ams_buf_ctrl_model.sv ***
// Buffer control stand-in that drives the next-character strobe.
// Assumes the busy flag comes from the sequencers on the same clock.
`timescale 1ns/1ps

module ams_buf_ctrl_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic busy,
	input wire logic [7:0] gap,
	output logic next_char_strobe
);
	logic [7:0] wait_cnt;
	logic hi_cnt;

	// =====================================================
	// Strobe generator
	// Gap stands for shifting a character out; the strobe is two periods
	// wide, so a design that counts levels instead of edges is caught
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_cnt <= 8'h00;
			hi_cnt <= 1'b0;
			next_char_strobe <= 1'b0;
		end
		else if (next_char_strobe)
		begin
			next_char_strobe <= hi_cnt;
			hi_cnt <= 1'b0;
		end
		else if (busy && wait_cnt >= gap)
		begin
			next_char_strobe <= 1'b1;
			hi_cnt <= 1'b1;
			wait_cnt <= 8'h00;
		end
		else
			wait_cnt <= busy ? wait_cnt + 8'h01 : 8'h00;
	end
endmodule // ams_buf_ctrl_model

// *** test/tb_auto_message_sequencers.sv ***
// Self-checking bench for the automatic message sequencers.
// Assumes the design top and the buffer control stand-in.
`timescale 1ns/1ps

module tb_auto_message_sequencers;
	import ams_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, morse_mode = 1'b0;
	logic [7:0] paddr = 8'h00, gap = 8'h06;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, strobe, er;
	logic [6:0] data_lines_n, last_d = 7'h7f;
	logic [15:0] id_select_n, last_s = 16'hffff;
	logic [7:0] fox_addr, last_f = 8'h00;
	ams_keys_n_t keys_n = 4'hf;
	ams_status_t status;
	int err_count = 0, cmp_count = 0;
	logic [15:0] dq[$], sq[$], fq[$];

	// =====================================================
	// Clock, design and partner
	always #2.5 pclk = ~pclk;

	ams_top #(.FLUSH_DIV(2), .ID_DEPTH(16)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .keys_n(keys_n),
		.morse_mode(morse_mode), .next_char_strobe(strobe),
		.data_lines_n(data_lines_n), .id_select_n(id_select_n),
		.fox_addr(fox_addr), .status(status));

	ams_buf_ctrl_model u_buf (.pclk(pclk), .presetn(presetn),
		.busy(status.sequencer_busy), .gap(gap), .next_char_strobe(strobe));

	// =====================================================
	// Change recorders; idle codes skipped since a restart idles for a cycle
	always @(posedge pclk)
	begin
		if (data_lines_n !== last_d && data_lines_n !== 7'h7f)
			dq.push_back({9'h0, ~data_lines_n});
		if (id_select_n !== last_s && id_select_n !== 16'hffff)
			sq.push_back(~id_select_n);
		if (fox_addr !== last_f && fox_addr !== 8'h00)
			fq.push_back({8'h0, fox_addr});
		last_d <= data_lines_n;
		last_s <= id_select_n;
		last_f <= fox_addr;
	end

	// =====================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			err_count++;
			$display("unexpected at %0t: bus never answered", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic press(input logic [3:0] k, input int hold);
		@(posedge pclk);
		keys_n <= ~k;
		repeat (hold) @(posedge pclk);
		keys_n <= 4'hf;
	endtask

	// Bounded wait until nothing runs
	task automatic idle_wait;
		int n;
		n = 0;
		while (status.sequencer_busy !== 1'b0 && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
		if (status.sequencer_busy !== 1'b0)
		begin
			err_count++;
			$display("unexpected at %0t: sequencers never idle", $time);
		end
		repeat (4) @(posedge pclk);
	endtask

	task automatic seq3(input logic [6:0] a, b, c, input int base);
		chk(dq[base], a);
		chk(dq[base + 1], b);
		chk(dq[base + 2], c);
	endtask

	// =====================================================
	// Scenarios
	task automatic t_reset;
		chk(data_lines_n, 7'h7f);
		chk(id_select_n, 16'hffff);
		chk(status, 5'h00);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h4);
	endtask

	task automatic t_regs;
		apb(1'b1, 8'h04, 32'h004b4a49);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h004b4a49);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, 8'h00, 32'h4);
	endtask

	task automatic t_call;
		dq.delete();
		press(4'h2, 8);
		press(4'h4, 6);
		chk(status.identifier_running, 1'b0);
		chk(status.group_running, 1'b1);
		chk(status.keyboard_inhibit, 1'b1);
		idle_wait;
		chk(dq.size(), 3);
		seq3(7'h43, 7'h51, 7'h20, 0);
		chk(status.group_running, 1'b0);
	endtask

	task automatic t_aux;
		dq.delete();
		gap <= 8'h01;
		press(4'h1, 8);
		idle_wait;
		seq3(7'h49, 7'h4a, 7'h4b, 0);
	endtask

	// Key held through the end of a string must restart it
	task automatic t_hold;
		dq.delete();
		press(4'h2, 24);
		idle_wait;
		seq3(7'h43, 7'h51, 7'h20, 3);
	endtask

	// Last stored code is zero; the identifier stops before the end slot's code reaches the lines
	task automatic t_id;
		logic [6:0] ch[5];
		ch = '{7'h53, 7'h54, 7'h4e, 7'h31, 7'h00};
		for (int i = 0; i < 5; i++)
			apb(1'b1, 8'h08, {17'h0, ch[i], 4'h0, i[3:0]});
		dq.delete();
		sq.delete();
		gap <= 8'h04;
		press(4'h4, 8);
		chk(status.sequencer_busy, 1'b1);
		idle_wait;
		chk(dq.size(), 4);
		for (int i = 0; i < 4; i++)
		begin
			chk(dq[i], ch[i]);
			chk(sq[i], 16'h1 << i);
		end
		chk(status.identifier_running, 1'b0);
		// Key held past the end marker sends the message again at once
		dq.delete();
		gap <= 8'h01;
		press(4'h4, 24);
		idle_wait;
		chk(dq.size(), 8);
		for (int i = 0; i < 4; i++)
			chk(dq[i + 4], ch[i]);
	endtask

	task automatic t_prio;
		press(4'h6, 8);
		chk(status.identifier_running, 1'b1);
		chk(status.group_running, 1'b0);
		idle_wait;
	endtask

	task automatic t_morse;
		morse_mode <= 1'b1;
		press(4'h8, 8);
		repeat (10) @(posedge pclk);
		chk({status.fox_active, fox_addr}, 9'h0);
		morse_mode <= 1'b0;
	endtask

	// Fox left running when Morse is chosen must flush with no strobes
	task automatic t_flush;
		gap <= 8'hff;
		press(4'h8, 4);
		morse_mode <= 1'b1;
		repeat (10) @(posedge pclk);
		chk(status.fox_active, 1'b1);
		repeat (130) @(posedge pclk);
		chk({status.fox_active, fox_addr}, 9'h0);
		morse_mode <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	task automatic t_fox;
		logic [5:0] k;
		fq.delete();
		gap <= 8'h01;
		press(4'h8, 8);
		idle_wait;
		for (int i = 1; i < 63; i++)
		begin
			k = i[5:0];
			chk(fq[i - 1], {k[5], 2'b00, k[4:0]});
		end
	endtask

	// =====================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_regs;
		t_call;
		t_aux;
		t_hold;
		t_id;
		t_prio;
		t_morse;
		t_flush;
		t_fox;
		conclude;
	end

	// The run needs under two thousand cycles; this allows over thirty times that
	initial
	begin
		#300000;
		err_count++;
		conclude;
	end
endmodule // tb_auto_message_sequencers
